// [tnrb_bus_master.sv]
// Byte-level two-wire bus master standing in for the host
`timescale 1ns/1ps
module tnrb_bus_master (
    // Clock
    input wire ref_clk,
    // Byte stream towards the bank
    output logic frame_start,
    output logic frame_stop,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    initial begin
        frame_start = 1'b0;
        frame_stop = 1'b0;
        byte_valid = 1'b0;
        byte_data = 8'hA5;
    end
    // Address byte first, then data, stop and an idle gap
    task automatic send(input logic [7:0] q[$]);
        @(posedge ref_clk);
        frame_start <= 1'b1;
        foreach (q[i]) begin
            @(posedge ref_clk);
            frame_start <= 1'b0;
            byte_valid <= 1'b1;
            byte_data <= q[i];
        end
        @(posedge ref_clk);
        byte_valid <= 1'b0;
        byte_data <= ~q[q.size() - 1];
        frame_stop <= 1'b1;
        @(posedge ref_clk);
        frame_stop <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
endmodule // tnrb_bus_master

// [tnrb_map.vh]
// Register indices, field positions and reset values of the tuner write bank
`ifndef TNRB_MAP_VH
`define TNRB_MAP_VH
`define TNRB_IDX_DIV_HIGH 4'h2
`define TNRB_IDX_DIV_LOW 4'h3
`define TNRB_IDX_GAIN 4'h4
`define TNRB_IDX_PORT0 4'h5
`define TNRB_IDX_FILTER 4'h6
`define TNRB_IDX_PORT1 4'h7
`define TNRB_IDX_PUMP 4'h8
`define TNRB_IDX_LOBAND 4'h9
`define TNRB_IDX_SAMPLE 4'hA
`define TNRB_IDX_WINDOW 4'hB
`define TNRB_IDX_TEST 4'hC
`define TNRB_IDX_POWER 4'hD
`define TNRB_RST_DIV_HIGH 8'h00
`define TNRB_RST_DIV_LOW 8'h00
`define TNRB_RST_GAIN 8'h80
`define TNRB_RST_PORT0 8'h00
`define TNRB_RST_FILTER 8'hC0
`define TNRB_RST_PORT1 8'h20
`define TNRB_RST_PUMP 8'hDB
`define TNRB_RST_LOBAND 8'h30
`define TNRB_RST_SAMPLE 8'hE1
`define TNRB_RST_WINDOW_A 8'h75
`define TNRB_RST_WINDOW_B 8'hF5
`define TNRB_RST_TEST 8'hF0
`define TNRB_RST_POWER 8'h28
// Fixed bit masks and patterns per register
`define TNRB_FIX_DIV_HIGH_MASK 8'h80
`define TNRB_FIX_DIV_HIGH_VAL 8'h00
`define TNRB_FIX_GAIN_MASK 8'hC0
`define TNRB_FIX_GAIN_VAL 8'h80
`define TNRB_FIX_FILTER_MASK 8'hF7
`define TNRB_FIX_FILTER_VAL 8'hC0
`define TNRB_FIX_PORT1_MASK 8'h01
`define TNRB_FIX_PORT1_VAL 8'h00
`define TNRB_FIX_PUMP_MASK 8'hFB
`define TNRB_FIX_PUMP_VAL 8'hD3
`define TNRB_FIX_SAMPLE_MASK 8'hF8
`define TNRB_FIX_SAMPLE_VAL 8'hE0
`define TNRB_FIX_TEST_MASK 8'hFF
`define TNRB_FIX_TEST_VAL 8'hF0
// Write address prefix and direction
`define TNRB_ADDR_PREFIX 5'h18
`define TNRB_DIR_WRITE 1'b0
// Field positions
`define TNRB_RF_GAIN_BIT 5
`define TNRB_BYPASS_BIT 0
`define TNRB_PORT_BIT 7
`define TNRB_RSW_BIT 3
`define TNRB_PUMP_BIT 2
`define TNRB_ALGO_BIT 7
`define TNRB_WSEL_BIT 7
`define TNRB_RELAX_BIT 0
`define TNRB_PD_BIT 7
`define TNRB_CLR_BIT 1
`define TNRB_LOSEL_BIT 0
`endif

// [tnrb_properties.sv]
// Concurrent checks on the tuner write bank ports
`timescale 1ns/1ps
module tnrb_properties (
    // Clock, reset and byte stream
    input wire ref_clk,
    input wire sys_rst,
    input wire byte_valid,
    input wire [7:0] byte_data,
    input wire frame_start,
    input wire [1:0] pin_address_bits,
    input wire byte_ack,
    // Register outputs
    input wire [14:0] divide_ratio,
    input wire rf_gain_boost,
    input wire [1:0] prefilter_gain,
    input wire [1:0] postfilter_gain,
    input wire rf_bypass_disable,
    input wire [1:0] gp_output_ports_out,
    input wire [1:0] gp_output_ports_oe,
    input wire resistor_switch_off,
    input wire [5:0] filter_bandwidth,
    input wire logic_reset_bit,
    input wire power_down_bit,
    input wire [4:0] filter_ref_select,
    input wire [2:0] tuning_sample_rate,
    input wire [7:0] test_only
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    reg [7:0] last_byte;
    reg [7:0] prev_byte;
    always @(posedge ref_clk) begin
        if (byte_valid) begin
            prev_byte <= last_byte;
            last_byte <= byte_data;
        end
    end
    sequence s_addr;
        frame_start ##1 (byte_valid && byte_data == {5'h18, pin_address_bits, 1'b0});
    endsequence
    sequence s_bad;
        frame_start ##1 (byte_valid && byte_data != {5'h18, pin_address_bits, 1'b0});
    endsequence
    a_ack_with_byte: assert property (byte_ack |-> byte_valid) else $error("ack without byte");
    a_addr_ack: assert property (s_addr |-> byte_ack) else $error("address not acked");
    a_bad_addr_nak: assert property (s_bad |-> (!byte_ack)[*5]) else $error("foreign frame acked");
    a_port_open_drain: assert property (gp_output_ports_out == 2'h0) else $error("port driven high");
    a_reset_defaults: assert property ($fell(sys_rst) |-> divide_ratio == 15'h0000 && gp_output_ports_oe == 2'h0
        && test_only == 8'hF0 && filter_ref_select == 5'h0A) else $error("bad reset value");
    a_ratio_write: assert property (s_addr ##1 (byte_valid && !byte_data[7]) ##1 byte_valid
        |=> divide_ratio == {prev_byte[6:0], last_byte}) else $error("ratio not written");
    a_gain_write: assert property (s_addr ##1 (byte_valid && byte_data[7:6] == 2'h2) |=> {rf_gain_boost,
        prefilter_gain, postfilter_gain, rf_bypass_disable} == last_byte[5:0]) else $error("gain wrong");
    a_port1_write: assert property (s_addr ##1 (byte_valid && byte_data[7:4] == 4'hC) ##1 byte_valid
        |=> gp_output_ports_oe[1] == last_byte[7] && filter_bandwidth == last_byte[6:1]
        && resistor_switch_off == prev_byte[3]) else $error("pair six wrong");
    a_logic_reset: assert property ($rose(logic_reset_bit) |=> !logic_reset_bit && !power_down_bit
        && tuning_sample_rate == 3'h1 && test_only == 8'hF0) else $error("logic reset failed");
endmodule // tnrb_properties
bind tnrb_write_bank tnrb_properties u_props (.*);

// [tnrb_write_bank.v]
// Write-only control register bank of the tuner, loaded over the two-wire bus
`timescale 1ns/1ps
// Summary of operation
// R1: Fifteen-bit divide ratio across bytes two, three
// R2: Conversion frequency equals comparison frequency times ratio
// R3: Byte four bit five adds RF gain
// R4: Byte four bits 4..3 select prefilter gain
// R5: Byte four bits 2..1 select postfilter gain
// R6: Byte four bit zero disables RF bypass
// R7: Port bits drive open-drain outputs low
// R8: Every register takes its power-on default
// R9: Byte five holds pump current, reference divider
// R10: Byte six holds resistor switch disable bit
// R11: Byte seven holds six-bit filter bandwidth
// R12: Byte nine holds algorithm disable, LO bands
// R13: Byte ten holds tuning sample rate
// R14: Byte eleven holds tuning window fields
// R15: Byte twelve is test only, fixed F0
// R16: Byte thirteen holds power, reference, reset, LO
// R17: Data accepted only after matching write address
// R18: Byte eight holds charge pump control bit
// R19: Leading data bits select starting even byte
// R20: Master writes fixed bits with default values
module tnrb_write_bank #(
    parameter WINDOW_RESET_HIGH = 1'b0
) (
    // Clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // Two-wire bus byte stream from the bus front end
    input wire byte_valid,
    input wire [7:0] byte_data,
    input wire frame_start,
    input wire frame_stop,
    // Pin-selected address bits
    input wire [1:0] pin_address_bits,
    // Acknowledge back to the bus front end
    output wire byte_ack,
    // Divide ratio
    output wire [14:0] divide_ratio,
    // Gain and bypass
    output wire rf_gain_boost,
    output wire [1:0] prefilter_gain,
    output wire [1:0] postfilter_gain,
    output wire rf_bypass_disable,
    // Open-drain general-purpose ports, output always low
    output wire [1:0] gp_output_ports_out,
    output wire [1:0] gp_output_ports_oe,
    // Synthesizer and filter controls
    output wire [1:0] pump_current_sel,
    output wire [4:0] ref_divider_sel,
    output wire resistor_switch_off,
    output wire [5:0] filter_bandwidth,
    output wire pump_control_bit,
    output wire tuning_algo_off,
    output wire [2:0] lo_main_band,
    output wire [3:0] lo_sub_band,
    output wire [2:0] tuning_sample_rate,
    output wire window_select,
    output wire [2:0] window_high_level,
    output wire [2:0] window_low_level,
    output wire window_relax_enable,
    output wire power_down_bit,
    output wire [4:0] filter_ref_select,
    output wire logic_reset_bit,
    output wire lo_output_select,
    output wire [7:0] test_only
);
`include "tnrb_map.vh"

    localparam ST_IDLE = 2'b00;
    localparam ST_ADDR = 2'b01;
    localparam ST_DATA = 2'b10;
    localparam ST_SKIP = 2'b11;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [3:0] index;
    reg [3:0] next_index;
    localparam [7:0] WINDOW_RESET_VALUE = WINDOW_RESET_HIGH ? `TNRB_RST_WINDOW_B : `TNRB_RST_WINDOW_A;

    reg clr_pending;
    reg [1:0] pin_sync_first;
    reg [1:0] pin_sync;
    reg [7:0] regs [2:13];
    reg [3:0] start_index;
    wire [7:0] window_default;
    wire addr_match;
    wire data_write;
    wire [3:0] target_index;
    wire clr_request;
    wire [13:2] reg_write;
    wire [13:2] reg_restore;
    wire [7:0] divider_ratio_high;
    wire [7:0] divider_ratio_low;
    wire [7:0] gain_and_bypass_ctrl;
    wire [7:0] port0_pump_refdiv;
    wire [7:0] filter_switch_ctrl;
    wire [7:0] port1_bandwidth;
    wire [7:0] pump_control;
    wire [7:0] lo_band_select;
    wire [7:0] tuning_window;
    wire [7:0] power_refsel_reset;

    // Address pins pass two flops before the comparator
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_sync_first <= 2'h0;
            pin_sync <= 2'h0;
        end else begin
            pin_sync_first <= pin_address_bits;
            pin_sync <= pin_sync_first;
        end
    end

    assign window_default = WINDOW_RESET_VALUE; // R14
    assign addr_match = (byte_data[7:3] == `TNRB_ADDR_PREFIX) && (byte_data[2:1] == pin_sync)
        && (byte_data[0] == `TNRB_DIR_WRITE); // R17

    // Starting even byte from the leading bits of the first data byte
    always @* begin
        case (byte_data[7:6])
            2'b10: start_index = `TNRB_IDX_GAIN; // R19
            2'b11: begin
                case (byte_data[5:4])
                    2'b00: start_index = `TNRB_IDX_FILTER; // R19
                    2'b01: start_index = `TNRB_IDX_PUMP; // R19
                    2'b10: start_index = `TNRB_IDX_SAMPLE; // R19
                    default: start_index = `TNRB_IDX_TEST; // R19
                endcase
            end
            default: start_index = `TNRB_IDX_DIV_HIGH; // R19
        endcase
    end

    assign target_index = (index == 4'h0) ? start_index : index; // R19
    assign data_write = byte_valid && (state == ST_DATA) && (target_index <= `TNRB_IDX_POWER);
    assign byte_ack = byte_valid && ((state == ST_ADDR && addr_match) || state == ST_DATA);
    assign clr_request = data_write && (target_index == `TNRB_IDX_POWER) && byte_data[`TNRB_CLR_BIT];

    always @* begin
        next_state = state;
        next_index = index;
        case (state)
            ST_IDLE: begin
                if (frame_start) begin
                    next_state = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (byte_valid) begin
                    next_state = addr_match ? ST_DATA : ST_SKIP; // R17
                    next_index = 4'h0;
                end
            end
            ST_DATA: begin
                if (byte_valid) begin
                    // Bytes past the last register are ignored
                    next_index = (target_index > `TNRB_IDX_POWER) ? target_index : target_index + 4'h1;
                end
            end
            ST_SKIP: begin
                next_state = ST_SKIP;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // Stop abandons the frame in any state
        if (frame_stop) begin
            next_state = ST_IDLE;
        end
        // A repeated start reopens address matching
        if (frame_start) begin
            next_state = ST_ADDR;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            index <= 4'h0;
        end else begin
            state <= next_state;
            index <= next_index;
        end
    end

    // Write data merged with fixed patterns per register
    function [7:0] fix_bits;
        input [3:0] idx;
        input [7:0] din;
        begin
            case (idx)
                `TNRB_IDX_DIV_HIGH: fix_bits = (din & ~`TNRB_FIX_DIV_HIGH_MASK) | `TNRB_FIX_DIV_HIGH_VAL;
                `TNRB_IDX_GAIN: fix_bits = (din & ~`TNRB_FIX_GAIN_MASK) | `TNRB_FIX_GAIN_VAL;
                `TNRB_IDX_FILTER: fix_bits = (din & ~`TNRB_FIX_FILTER_MASK) | `TNRB_FIX_FILTER_VAL;
                `TNRB_IDX_PORT1: fix_bits = (din & ~`TNRB_FIX_PORT1_MASK) | `TNRB_FIX_PORT1_VAL;
                `TNRB_IDX_PUMP: fix_bits = (din & ~`TNRB_FIX_PUMP_MASK) | `TNRB_FIX_PUMP_VAL;
                `TNRB_IDX_SAMPLE: fix_bits = (din & ~`TNRB_FIX_SAMPLE_MASK) | `TNRB_FIX_SAMPLE_VAL;
                `TNRB_IDX_TEST: fix_bits = (din & ~`TNRB_FIX_TEST_MASK) | `TNRB_FIX_TEST_VAL;
                default: fix_bits = din;
            endcase
        end
    endfunction

    function [7:0] reset_value;
        input [3:0] idx;
        input [7:0] win;
        begin
            case (idx)
                `TNRB_IDX_DIV_HIGH: reset_value = `TNRB_RST_DIV_HIGH;
                `TNRB_IDX_DIV_LOW: reset_value = `TNRB_RST_DIV_LOW;
                `TNRB_IDX_GAIN: reset_value = `TNRB_RST_GAIN;
                `TNRB_IDX_PORT0: reset_value = `TNRB_RST_PORT0;
                `TNRB_IDX_FILTER: reset_value = `TNRB_RST_FILTER;
                `TNRB_IDX_PORT1: reset_value = `TNRB_RST_PORT1;
                `TNRB_IDX_PUMP: reset_value = `TNRB_RST_PUMP;
                `TNRB_IDX_LOBAND: reset_value = `TNRB_RST_LOBAND;
                `TNRB_IDX_SAMPLE: reset_value = `TNRB_RST_SAMPLE;
                `TNRB_IDX_WINDOW: reset_value = win;
                `TNRB_IDX_TEST: reset_value = `TNRB_RST_TEST;
                default: reset_value = `TNRB_RST_POWER;
            endcase
        end
    endfunction

    // Logic reset restores bytes 7 and 9..13 one cycle after the write
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clr_pending <= 1'b0;
        end else begin
            clr_pending <= clr_request;
        end
    end

    genvar g;
    generate
        for (g = 2; g <= 13; g = g + 1) begin : gen_reg
            localparam [3:0] IDX = g;
            assign reg_restore[g] = clr_pending && (IDX == `TNRB_IDX_PORT1 || IDX >= `TNRB_IDX_LOBAND); // R16
            assign reg_write[g] = data_write && (target_index == IDX);
            always @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    regs[g] <= reset_value(IDX, WINDOW_RESET_VALUE); // R8
                end else if (reg_restore[g]) begin
                    regs[g] <= reset_value(IDX, window_default);
                end else if (reg_write[g]) begin
                    regs[g] <= fix_bits(IDX, byte_data); // R20
                end
            end
        end
    endgenerate

    // Named views of the bank
    assign divider_ratio_high = regs[`TNRB_IDX_DIV_HIGH];
    assign divider_ratio_low = regs[`TNRB_IDX_DIV_LOW];
    assign gain_and_bypass_ctrl = regs[`TNRB_IDX_GAIN];
    assign port0_pump_refdiv = regs[`TNRB_IDX_PORT0];
    assign filter_switch_ctrl = regs[`TNRB_IDX_FILTER];
    assign port1_bandwidth = regs[`TNRB_IDX_PORT1];
    assign pump_control = regs[`TNRB_IDX_PUMP];
    assign lo_band_select = regs[`TNRB_IDX_LOBAND];
    assign tuning_window = regs[`TNRB_IDX_WINDOW];
    assign power_refsel_reset = regs[`TNRB_IDX_POWER];

    // Divide ratio and front-end gains
    assign divide_ratio = {divider_ratio_high[6:0], divider_ratio_low}; // R1 R2
    assign rf_gain_boost = gain_and_bypass_ctrl[`TNRB_RF_GAIN_BIT]; // R3
    assign prefilter_gain = gain_and_bypass_ctrl[4:3]; // R4
    assign postfilter_gain = gain_and_bypass_ctrl[2:1]; // R5
    assign rf_bypass_disable = gain_and_bypass_ctrl[`TNRB_BYPASS_BIT]; // R6

    // Open-drain ports pull the pin low while enabled, never drive high
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_port
            assign gp_output_ports_out[g] = 1'b0;
            assign gp_output_ports_oe[g] = (g == 0) ? port0_pump_refdiv[`TNRB_PORT_BIT]
                : port1_bandwidth[`TNRB_PORT_BIT]; // R7
        end
    endgenerate

    // Synthesizer, filter and LO band controls
    assign pump_current_sel = port0_pump_refdiv[6:5]; // R9
    assign ref_divider_sel = port0_pump_refdiv[4:0]; // R9
    assign resistor_switch_off = filter_switch_ctrl[`TNRB_RSW_BIT]; // R10
    assign filter_bandwidth = port1_bandwidth[6:1]; // R11
    assign pump_control_bit = pump_control[`TNRB_PUMP_BIT]; // R18
    assign tuning_algo_off = lo_band_select[`TNRB_ALGO_BIT]; // R12
    assign lo_main_band = lo_band_select[6:4]; // R12
    assign lo_sub_band = lo_band_select[3:0]; // R12
    assign tuning_sample_rate = regs[`TNRB_IDX_SAMPLE][2:0]; // R13

    // Tuning window, test and power controls
    assign window_select = tuning_window[`TNRB_WSEL_BIT]; // R14
    assign window_high_level = tuning_window[6:4]; // R14
    assign window_low_level = tuning_window[3:1]; // R14
    assign window_relax_enable = tuning_window[`TNRB_RELAX_BIT]; // R14
    assign test_only = regs[`TNRB_IDX_TEST]; // R15
    assign power_down_bit = power_refsel_reset[`TNRB_PD_BIT]; // R16
    assign filter_ref_select = power_refsel_reset[6:2]; // R16
    assign logic_reset_bit = power_refsel_reset[`TNRB_CLR_BIT]; // R16
    assign lo_output_select = power_refsel_reset[`TNRB_LOSEL_BIT]; // R16

endmodule // tnrb_write_bank

// [tuner_write_register_bank_bench.sv]
// Self-checking bench for the tuner write bank
`timescale 1ns/1ps
module tuner_write_register_bank_bench;
    localparam logic [7:0] RST [2:13] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'hC0, 8'h20, 8'hDB, 8'h30, 8'hE1, 8'h75,
        8'hF0, 8'h28};
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] pin_address_bits = 2'h0;
    wire frame_start, frame_stop, byte_valid, byte_ack, rf_gain_boost, rf_bypass_disable, resistor_switch_off;
    wire pump_control_bit, tuning_algo_off, window_select, window_relax_enable, power_down_bit, logic_reset_bit;
    wire lo_output_select;
    wire [7:0] byte_data, test_only;
    wire [14:0] divide_ratio;
    wire [1:0] prefilter_gain, postfilter_gain, gp_output_ports_out, gp_output_ports_oe, pump_current_sel;
    wire [4:0] ref_divider_sel, filter_ref_select;
    wire [5:0] filter_bandwidth;
    wire [2:0] lo_main_band, tuning_sample_rate, window_high_level, window_low_level;
    wire [3:0] lo_sub_band;
    int failures = 0;
    int compares = 0;
    logic [7:0] seed = 8'h5B;
    logic [7:0] regs [2:13];
    logic [97:0] expq [$];
    logic [7:0] q [$];
    wire [97:0] seen = {gp_output_ports_out, 1'b0, divide_ratio, 2'h2, rf_gain_boost, prefilter_gain,
        postfilter_gain, rf_bypass_disable, gp_output_ports_oe[0], pump_current_sel, ref_divider_sel, 4'hC,
        resistor_switch_off, 3'h0, gp_output_ports_oe[1], filter_bandwidth, 1'b0, 5'h1A, pump_control_bit, 2'h3,
        tuning_algo_off, lo_main_band, lo_sub_band, 5'h1C, tuning_sample_rate, window_select, window_high_level,
        window_low_level, window_relax_enable, test_only, power_down_bit, filter_ref_select, logic_reset_bit,
        lo_output_select};
    tnrb_write_bank dut (.*);
    tnrb_bus_master mst (.ref_clk(ref_clk), .frame_start(frame_start), .frame_stop(frame_stop),
        .byte_valid(byte_valid), .byte_data(byte_data));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Fixed-bit mask in the upper byte, pattern in the lower
    function automatic logic [15:0] fixed(input int i);
        case (i)
            2: return 16'h8000;
            4: return 16'hC080;
            6: return 16'hF7C0;
            7: return 16'h0100;
            8: return 16'hFBD3;
            10: return 16'hF8E0;
            12: return 16'hFFF0;
            default: return 16'h0000;
        endcase
    endfunction
    task automatic restore(input bit all);
        for (int i = 2; i <= 13; i++)
            if (all || i == 7 || i >= 9) regs[i] = RST[i];
    endtask
    task automatic frame(input int first, input int n, input bit clr, input logic [7:0] bad);
        logic [15:0] f;
        logic [7:0] v;
        logic [97:0] e;
        q = {};
        q.push_back({5'h18, pin_address_bits, 1'b0} ^ bad);
        for (int i = first; i < first + n; i++) begin
            seed = lfsr(seed);
            f = fixed(i);
            v = (seed & ~f[15:8]) | f[7:0];
            if (i == 13) v[1] = clr;
            q.push_back(v);
            if (i <= 13 && bad == 8'h00) regs[i] = v;
        end
        if (clr && bad == 8'h00) restore(1'b0);
        e = 98'h0;
        // Bits with no output carry their fixed pattern
        for (int i = 2; i <= 13; i++) begin
            f = fixed(i);
            e = {e[89:0], (regs[i] & ~f[15:8]) | f[7:0]};
        end
        expq.push_back(e);
        mst.send(q);
    endtask
    task automatic check(input logic [97:0] got, input logic [97:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (frame_stop === 1'b1 && expq.size() > 0) begin
            #1;
            check(seen, expq.pop_front());
        end
    end
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        failures++;
        conclude();
    end
    initial begin
        restore(1'b1);
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Foreign pins, read direction, wrong prefix
        frame(2, 2, 1'b0, 8'h02);
        frame(4, 2, 1'b0, 8'h01);
        frame(2, 2, 1'b0, 8'h80);
        // Full bank per pin setting, one byte past the end
        for (int p = 0; p < 4; p++) begin
            @(posedge ref_clk);
            pin_address_bits <= p[1:0];
            @(posedge ref_clk);
            frame(2, 13, 1'b0, 8'h00);
        end
        // Every start selector, top pair first
        for (int k = 0; k < 6; k++) frame(12 - 2 * k, 2, 1'b0, 8'h00);
        frame(12, 2, 1'b1, 8'h00);
        frame(6, 4, 1'b0, 8'h00);
        // Second reset in mid-run
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        restore(1'b1);
        frame(2, 2, 1'b0, 8'h02);
        frame(4, 2, 1'b0, 8'h00);
        repeat (4) @(posedge ref_clk);
        conclude();
    end
endmodule // tuner_write_register_bank_bench
